// *** hdl/mlf_lock_resp.sv ***
// motor lock fault response: apb registers, response state machine, gate commands
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
module mlf_lock_resp
  import mlf_pkg::*;
#(
  parameter logic [31:0] CYC_T0   = MLF_T0_CYC,
  parameter logic [31:0] CYC_T1   = MLF_T1_CYC,
  parameter logic [31:0] CYC_STEP = MLF_STEP_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             lock_detect,
  input  wire logic             motor_running,
  input  wire logic             probe_timeout,
  input  wire logic             probe_rate_err,
  input  wire logic             cur_loop_sat,
  input  wire logic             spd_loop_sat,
  output mlf_pkg::mlf_gate_t    gate_cmd,
  output logic                  fault_out_low,
  output logic                  cur_sat_flag,
  output logic                  spd_sat_flag,
  output logic                  irq
);
  import mlf_pkg::*;

  logic [10:0]        setup_q, setup_d;
  logic [2:0]         limit_q, limit_d;
  logic [MLF_NEV-1:0] mask_q, mask_d;
  logic [31:0]        rdata_q, rdata_d;
  logic               ready_q, ready_d, err_q, err_d;
  mlf_state_t         state_q, state_d;
  logic [3:0]         tries_q, tries_d;
  mlf_gate_t          gate_q, gate_d;
  logic               nflt_q, nflt_d;
  logic               csat_q, csat_d, ssat_q, ssat_d;
  logic               tmo_q, tmo_d, frq_q, frq_d;
  logic [MLF_NEV-1:0] ev, clr, status, side_ev, all_ev;
  logic               tmr_start, tmr_abort, tmr_done;
  logic               wr_acc, rd_acc, fault_clear;
  logic [3:0]         resp, rcode;
  logic               irq_w;

  assign resp  = setup_q[MLF_RESP_LSB +: 4];
  assign rcode = setup_q[MLF_RETRY_LSB +: 4];

  // apb: one wait state per access phase, answer registered at the first access edge
  assign wr_acc = psel && penable && pwrite && !ready_q;
  assign rd_acc = psel && penable && !pwrite && !ready_q;

  always_comb begin
    setup_d     = setup_q;
    limit_d     = limit_q;
    mask_d      = mask_q;
    rdata_d     = 32'h00000000;
    ready_d     = psel && penable && !ready_q;
    err_d       = 1'b0;
    clr         = '0;
    fault_clear = 1'b0;
    if (wr_acc) begin
      case (paddr)
        MLF_OFS_SETUP:  setup_d = pwdata[10:0];
        MLF_OFS_LIMIT:  limit_d = pwdata[2:0];
        MLF_OFS_STATUS: clr     = pwdata[MLF_NEV-1:0];
        MLF_OFS_MASK:   mask_d  = pwdata[MLF_NEV-1:0];
        MLF_OFS_CTRL:   fault_clear = pwdata[0];
        MLF_OFS_STATE:  ;
        default:        err_d = 1'b1;
      endcase
    end else if (rd_acc) begin
      case (paddr)
        MLF_OFS_SETUP:  rdata_d = {21'h000000, setup_q};
        MLF_OFS_LIMIT:  rdata_d = {29'h00000000, limit_q};
        MLF_OFS_STATUS: rdata_d = {26'h0000000, status};
        MLF_OFS_MASK:   rdata_d = {26'h0000000, mask_q};
        MLF_OFS_CTRL:   rdata_d = 32'h00000000;
        MLF_OFS_STATE:  rdata_d = {22'h000000, tries_q, gate_q, nflt_q, 1'b0, state_q};
        default:        err_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      setup_q <= MLF_SETUP_RESET;
      limit_q <= MLF_LIMIT_RESET;
      mask_q  <= MLF_MASK_RESET;
      rdata_q <= 32'h00000000;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      setup_q <= setup_d;
      limit_q <= limit_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q   <= err_d;
    end
  end

  // lock response state machine
  always_comb begin
    state_d   = state_q;
    tries_d   = tries_q;
    gate_d    = gate_q;
    nflt_d    = nflt_q;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    ev        = '0;
    case (state_q)
      MLF_IDLE: begin
        gate_d = MLF_GATE_RUN;
        nflt_d = 1'b1;
        if (motor_running && !lock_detect) begin
          tries_d = 4'h0;
        end
        if (lock_detect && resp < MLF_RESP_REPORT) begin
          ev[MLF_ST_LOCK] = 1'b1;
          nflt_d          = 1'b0;
          if (resp < MLF_RESP_RETRY_LO) begin
            state_d = MLF_LATCH;
            ev[MLF_ST_LATCH] = 1'b1;
            case (resp)
              MLF_RESP_HS_LATCH: gate_d = MLF_GATE_HS;
              MLF_RESP_LS_LATCH: gate_d = MLF_GATE_LS;
              default:           gate_d = MLF_GATE_HIZ;
            endcase
          end else if ({1'b0, limit_q} < tries_q) begin
            state_d = MLF_LATCH;
            ev[MLF_ST_LATCH] = 1'b1;
            case (resp)
              MLF_RESP_RETRY_HS: gate_d = MLF_GATE_HS;
              MLF_RESP_RETRY_LS: gate_d = MLF_GATE_LS;
              default:           gate_d = MLF_GATE_HIZ;
            endcase
          end else begin
            state_d   = MLF_WAIT;
            gate_d    = MLF_GATE_HIZ;
            tmr_start = 1'b1;
          end
        end else if (lock_detect && resp == MLF_RESP_REPORT) begin
          state_d         = MLF_FAULT;
          ev[MLF_ST_LOCK] = 1'b1;
          nflt_d          = 1'b0;
        end
      end
      MLF_FAULT: begin
        gate_d = MLF_GATE_RUN;
        if (!lock_detect || resp != MLF_RESP_REPORT) begin
          state_d = MLF_IDLE;
          nflt_d  = 1'b1;
        end
      end
      MLF_WAIT: begin
        if (tmr_done) begin
          state_d = MLF_IDLE;
          tries_d = tries_q + 4'h1;
          gate_d  = MLF_GATE_RUN;
          nflt_d  = 1'b1;
          ev[MLF_ST_RETRY] = 1'b1;
        end
      end
      MLF_LATCH: begin
        if (fault_clear) begin
          state_d   = MLF_IDLE;
          tries_d   = 4'h0;
          gate_d    = MLF_GATE_RUN;
          nflt_d    = 1'b1;
          tmr_abort = 1'b1;
        end
      end
      default: begin
        state_d = MLF_IDLE;
      end
    endcase
  end

  // qualified side faults and saturation flags
  always_comb begin
    tmo_d  = probe_timeout && setup_q[MLF_TMO_EN_BIT];
    frq_d  = probe_rate_err && setup_q[MLF_FRQ_EN_BIT];
    csat_d = cur_loop_sat && setup_q[MLF_SAT_EN_BIT];
    ssat_d = spd_loop_sat && setup_q[MLF_SAT_EN_BIT];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= MLF_IDLE;
      tries_q <= 4'h0;
      gate_q  <= MLF_GATE_RUN;
      nflt_q  <= 1'b1;
      tmo_q   <= 1'b0;
      frq_q   <= 1'b0;
      csat_q  <= 1'b0;
      ssat_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      tries_q <= tries_d;
      gate_q  <= gate_d;
      nflt_q  <= nflt_d;
      tmo_q   <= tmo_d;
      frq_q   <= frq_d;
      csat_q  <= csat_d;
      ssat_q  <= ssat_d;
    end
  end

  // side faults and saturation join the lock events here, one driver each
  always_comb begin
    side_ev             = '0;
    side_ev[MLF_ST_TMO] = tmo_d;
    side_ev[MLF_ST_FRQ] = frq_d;
    side_ev[MLF_ST_SAT] = csat_d | ssat_d;
  end

  assign all_ev = ev | side_ev;

  mlf_retry_timer #(
    .CYC_T0   (CYC_T0),
    .CYC_T1   (CYC_T1),
    .CYC_STEP (CYC_STEP)
  ) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .start (tmr_start),
    .abort (tmr_abort),
    .code  (rcode),
    .done  (tmr_done)
  );

  mlf_event_regs u_events (
    .clk    (clk),
    .rst_n  (rst_n),
    .ev     (all_ev),
    .clr    (clr),
    .mask   (mask_q),
    .status (status),
    .irq    (irq_w)
  );

  assign prdata        = rdata_q;
  assign pready        = ready_q;
  assign pslverr       = err_q;
  assign gate_cmd      = gate_q;
  assign fault_out_low = nflt_q;
  assign cur_sat_flag  = csat_q;
  assign spd_sat_flag  = ssat_q;
  assign irq           = irq_w;

  // response rule checks
  a_latch_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MLF_IDLE && lock_detect && resp < MLF_RESP_HS_LATCH
    |=> state_q == MLF_LATCH && gate_q == MLF_GATE_HIZ && !nflt_q)
    else $error("latched tristate response missing");
  a_latch_holds: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MLF_LATCH && !fault_clear |=> state_q == MLF_LATCH && !nflt_q)
    else $error("latched fault released without a clear");
  a_latch_high_side: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MLF_IDLE && lock_detect && resp == MLF_RESP_HS_LATCH
    |=> gate_q == MLF_GATE_HS && !nflt_q)
    else $error("high side brake missing");
  a_latch_low_side: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MLF_IDLE && lock_detect && resp == MLF_RESP_LS_LATCH
    |=> gate_q == MLF_GATE_LS && !nflt_q)
    else $error("low side brake missing");
  a_retry_start: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MLF_IDLE && lock_detect && resp >= MLF_RESP_RETRY_LO
    && resp < MLF_RESP_REPORT && tries_q <= {1'b0, limit_q}
    |=> state_q == MLF_WAIT && gate_q == MLF_GATE_HIZ && !nflt_q)
    else $error("retry wait not entered");
  a_wait_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MLF_WAIT |-> gate_q == MLF_GATE_HIZ && !nflt_q)
    else $error("retry wait drives the bridge");
  a_retry_release: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MLF_WAIT && tmr_done |=> state_q == MLF_IDLE && nflt_q
    && tries_q == $past(tries_q) + 4'h1)
    else $error("retry release wrong");
  a_retry_exhaust: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MLF_IDLE && lock_detect && resp >= MLF_RESP_RETRY_LO
    && resp < MLF_RESP_REPORT && tries_q > {1'b0, limit_q}
    |=> state_q == MLF_LATCH && !nflt_q)
    else $error("retry limit did not latch");
  a_report_only: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MLF_IDLE && lock_detect && resp == MLF_RESP_REPORT
    |=> !nflt_q && gate_q == MLF_GATE_RUN)
    else $error("report only touched gates");
  a_report_holds: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MLF_FAULT |-> !nflt_q && gate_q == MLF_GATE_RUN)
    else $error("report state lost fault or touched gates");
  a_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MLF_IDLE && resp > MLF_RESP_REPORT |=> nflt_q && gate_q == MLF_GATE_RUN)
    else $error("disabled detection acted");
  a_probe_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !setup_q[MLF_TMO_EN_BIT] && !setup_q[MLF_FRQ_EN_BIT] |=> !tmo_q && !frq_q)
    else $error("probe fault raised while disabled");
  a_tmo_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !setup_q[MLF_TMO_EN_BIT] |=> !tmo_q)
    else $error("probe timeout raised while disabled");
  a_tmo_enabled: assert property (@(posedge clk) disable iff (!rst_n)
    setup_q[MLF_TMO_EN_BIT] && probe_timeout |=> tmo_q)
    else $error("enabled probe timeout not raised");
  a_rate_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !setup_q[MLF_FRQ_EN_BIT] |=> !frq_q)
    else $error("probe rate fault raised while disabled");
  a_sat_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !setup_q[MLF_SAT_EN_BIT] |=> !csat_q && !ssat_q)
    else $error("saturation shown while disabled");
  a_sat_enabled: assert property (@(posedge clk) disable iff (!rst_n)
    setup_q[MLF_SAT_EN_BIT] && cur_loop_sat |=> csat_q)
    else $error("enabled current loop saturation not shown");
  a_count_clear: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MLF_LATCH && fault_clear |=> tries_q == 4'h0)
    else $error("retry count not cleared");
  a_count_run_clear: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == MLF_IDLE && motor_running && !lock_detect |=> tries_q == 4'h0)
    else $error("retry count kept while running free");
  a_apb_one_wait: assert property (@(posedge clk) disable iff (!rst_n)
    psel && penable && !ready_q |=> ready_q)
    else $error("bus answer not one cycle after access");

  // main scenarios
  c_latch:  cover property (@(posedge clk) disable iff (!rst_n) state_q == MLF_LATCH);
  c_retry:  cover property (@(posedge clk) disable iff (!rst_n) state_q == MLF_WAIT ##1 state_q == MLF_IDLE);
  c_report: cover property (@(posedge clk) disable iff (!rst_n) state_q == MLF_FAULT);
  c_irq:    cover property (@(posedge clk) disable iff (!rst_n) irq_w);
  c_sat:    cover property (@(posedge clk) disable iff (!rst_n) csat_q && ssat_q);

endmodule : mlf_lock_resp

// *** hdl/mlf_pkg.sv ***
// package: constants, register map and types of the motor lock fault response block
package mlf_pkg;

  // register byte offsets
  localparam logic [7:0] MLF_OFS_SETUP    = 8'h00;
  localparam logic [7:0] MLF_OFS_LIMIT    = 8'h04;
  localparam logic [7:0] MLF_OFS_STATUS   = 8'h08;
  localparam logic [7:0] MLF_OFS_MASK     = 8'h0C;
  localparam logic [7:0] MLF_OFS_CTRL     = 8'h10;
  localparam logic [7:0] MLF_OFS_STATE    = 8'h14;

  // fault_setup_one field positions
  localparam int MLF_RETRY_LSB  = 7;
  localparam int MLF_RESP_LSB   = 3;
  localparam int MLF_TMO_EN_BIT = 2;
  localparam int MLF_FRQ_EN_BIT = 1;
  localparam int MLF_SAT_EN_BIT = 0;
  localparam logic [10:0] MLF_SETUP_RESET = 11'h000;
  localparam logic [2:0]  MLF_LIMIT_RESET = 3'h0;
  localparam logic [5:0]  MLF_MASK_RESET  = 6'h00;

  // status bit positions
  localparam int MLF_ST_LOCK  = 0;
  localparam int MLF_ST_LATCH = 1;
  localparam int MLF_ST_RETRY = 2;
  localparam int MLF_ST_TMO   = 3;
  localparam int MLF_ST_FRQ   = 4;
  localparam int MLF_ST_SAT   = 5;
  localparam int MLF_NEV      = 6;

  // stall response codes
  localparam logic [3:0] MLF_RESP_HS_LATCH  = 4'h2;
  localparam logic [3:0] MLF_RESP_LS_LATCH  = 4'h3;
  localparam logic [3:0] MLF_RESP_RETRY_LO  = 4'h4;
  localparam logic [3:0] MLF_RESP_RETRY_HS  = 4'h6;
  localparam logic [3:0] MLF_RESP_RETRY_LS  = 4'h7;
  localparam logic [3:0] MLF_RESP_REPORT    = 4'h8;

  // timing
  localparam longint MLF_CLK_HZ      = 100000000;
  localparam longint MLF_T0_MS       = 300;
  localparam longint MLF_T1_MS       = 500;
  localparam longint MLF_STEP_MS     = 1000;
  localparam longint MLF_CYC_PER_MS  = MLF_CLK_HZ / 1000;
  localparam logic [31:0] MLF_T0_CYC   = 32'(MLF_T0_MS * MLF_CYC_PER_MS);
  localparam logic [31:0] MLF_T1_CYC   = 32'(MLF_T1_MS * MLF_CYC_PER_MS);
  localparam logic [31:0] MLF_STEP_CYC = 32'(MLF_STEP_MS * MLF_CYC_PER_MS);

  // gate driver commands
  typedef enum logic [1:0] {
    MLF_GATE_RUN  = 2'h0,
    MLF_GATE_HIZ  = 2'h1,
    MLF_GATE_HS   = 2'h3,
    MLF_GATE_LS   = 2'h2
  } mlf_gate_t;

  // response states, gray along idle -> faulted -> waiting -> latched
  typedef enum logic [1:0] {
    MLF_IDLE  = 2'b00,
    MLF_FAULT = 2'b01,
    MLF_WAIT  = 2'b11,
    MLF_LATCH = 2'b10
  } mlf_state_t;

endpackage : mlf_pkg

// *** hdl/mlf_retry_timer.sv ***
// retry interval decoder and countdown timer
`timescale 1ns/10ps
module mlf_retry_timer
  import mlf_pkg::*;
#(
  parameter logic [31:0] CYC_T0   = MLF_T0_CYC,
  parameter logic [31:0] CYC_T1   = MLF_T1_CYC,
  parameter logic [31:0] CYC_STEP = MLF_STEP_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [3:0] code,
  output logic            done
);
  logic [31:0] cnt_q, cnt_d, load_v;
  logic        run_q, run_d, done_q, done_d;

  always_comb begin
    case (code)
      4'h0:    load_v = CYC_T0;
      4'h1:    load_v = CYC_T1;
      default: load_v = 32'(CYC_STEP * 32'(code - 4'h1));
    endcase
  end

  always_comb begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (abort) begin
      run_d = 1'b0;
    end else if (start) begin
      cnt_d = load_v - 32'h00000001;
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q == 32'h00000000) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q  <= 32'h00000000;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

  a_timer_expiry: assert property (@(posedge clk) disable iff (!rst_n)
    run_q && cnt_q == 32'h00000000 && !abort && !start |=> done_q)
    else $error("retry timer did not expire at zero");

endmodule : mlf_retry_timer

// *** hdl/mlf_event_regs.sv ***
// sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/10ps
module mlf_event_regs
  import mlf_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [MLF_NEV-1:0] ev,
  input  wire logic [MLF_NEV-1:0] clr,
  input  wire logic [MLF_NEV-1:0] mask,
  output logic      [MLF_NEV-1:0] status,
  output logic                    irq
);
  logic [MLF_NEV-1:0] st_q, st_d;
  logic               irq_q, irq_d;

  genvar g;
  generate
    for (g = 0; g < MLF_NEV; g++) begin : g_bit
      // a set in the same cycle as a clear wins
      always_comb st_d[g] = ev[g] | (st_q[g] & ~clr[g]);
    end
  endgenerate

  always_comb irq_d = |(st_d & mask);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q  <= '0;
      irq_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      irq_q <= irq_d;
    end
  end

  assign status = st_q;
  assign irq    = irq_q;

  a_set_wins_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ev[0] && clr[0] |=> st_q[0])
    else $error("event lost against clear");

endmodule : mlf_event_regs

// *** verif/mlf_stage_model.sv ***
// power stage model: turns a commanded stall into lock detection and reports rotation
`timescale 1ns/10ps
module mlf_stage_model
  import mlf_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               stall,
  input  wire mlf_pkg::mlf_gate_t gate_cmd,
  output logic                    lock_detect,
  output logic                    motor_running
);
  // the rotor only turns while the bridge drives it and nothing holds it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_detect   <= 1'b0;
      motor_running <= 1'b0;
    end else begin
      lock_detect   <= stall;
      motor_running <= (gate_cmd == MLF_GATE_RUN) && !stall;
    end
  end
endmodule : mlf_stage_model

// *** verif/test_motor_lock_fault_response.sv ***
// self-checking bench of the motor lock fault response block
`timescale 1ns/10ps
module test_motor_lock_fault_response;
  import mlf_pkg::*;
  localparam logic [31:0] T0   = 32'h1E;
  localparam logic [31:0] T1   = 32'h32;
  localparam logic [31:0] STEP = 32'h64;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        stall, lock_detect, motor_running, probe_timeout, probe_rate_err;
  logic        cur_loop_sat, spd_loop_sat, fault_out_low, cur_sat_flag, spd_sat_flag, irq;
  mlf_gate_t   gate_cmd;
  int          bad_count, comparisons;

  mlf_lock_resp #(.CYC_T0(T0), .CYC_T1(T1), .CYC_STEP(STEP)) dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lock_detect(lock_detect),
    .motor_running(motor_running), .probe_timeout(probe_timeout), .probe_rate_err(probe_rate_err),
    .cur_loop_sat(cur_loop_sat), .spd_loop_sat(spd_loop_sat), .gate_cmd(gate_cmd),
    .fault_out_low(fault_out_low), .cur_sat_flag(cur_sat_flag), .spd_sat_flag(spd_sat_flag), .irq(irq));

  mlf_stage_model stage_u (
    .clk(clk), .rst_n(rst_n), .stall(stall), .gate_cmd(gate_cmd),
    .lock_detect(lock_detect), .motor_running(motor_running));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      give_verdict();
    end
  endtask : apb

  task automatic setup(input logic [3:0] ri, input logic [3:0] resp, input logic [2:0] en);
    apb(1'b1, MLF_OFS_SETUP, {21'h0, ri, resp, en});
  endtask : setup

  task automatic wait_fault(input logic lvl, output int n);
    n = 0;
    while (fault_out_low !== lvl && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      bad_count++;
      give_verdict();
    end
  endtask : wait_fault

  // release the stall, clear any latch, let the motor run free, clear status
  task automatic recover();
    int n;
    stall <= 1'b0;
    apb(1'b1, MLF_OFS_CTRL, 32'h1);
    wait_fault(1'b1, n);
    tick(20);
    apb(1'b1, MLF_OFS_STATUS, 32'h3F);
  endtask : recover

  function automatic logic [1:0] latch_gate(input logic [3:0] c);
    case (c)
      4'h2, 4'h6: return MLF_GATE_HS;
      4'h3, 4'h7: return MLF_GATE_LS;
      default:    return MLF_GATE_HIZ;
    endcase
  endfunction : latch_gate

  function automatic int ivl(input int c);
    return (c == 0) ? int'(T0) : (c == 1) ? int'(T1) : (c - 1) * int'(STEP);
  endfunction : ivl

  initial begin
    int n;
    int ri_list [4];
    ri_list = '{0, 1, 2, 15};
    {psel, penable, pwrite, paddr, pwdata, stall} = '0;
    {probe_timeout, probe_rate_err, cur_loop_sat, spd_loop_sat} = '0;
    bad_count = 0;
    comparisons = 0;
    rst_n = 1'b0;
    tick(3);
    rst_n <= 1'b1;
    check(32'({gate_cmd, fault_out_low, irq}), 32'h2);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    setup(4'hA, 4'h5, 3'h3);
    apb(1'b0, MLF_OFS_SETUP, 32'h0);
    check(rd, 32'h52B);
    apb(1'b1, MLF_OFS_MASK, 32'h02);
    for (int c = 0; c < 4; c++) begin
      setup(4'h0, 4'(c), 3'h0);
      stall <= 1'b1;
      tick(5);
      stall <= 1'b0;
      tick(5);
      check(32'(gate_cmd), 32'(latch_gate(4'(c))));
      check(32'({fault_out_low, irq}), 32'h1);
      recover();
      check(32'({gate_cmd, fault_out_low, irq}), 32'h2);
    end
    for (int c = 8; c < 16; c++) begin
      setup(4'h0, 4'(c), 3'h0);
      stall <= 1'b1;
      tick(5);
      check(32'(fault_out_low), (c == 8) ? 32'h0 : 32'h1);
      check(32'(gate_cmd), 32'(MLF_GATE_RUN));
      stall <= 1'b0;
      tick(5);
      check(32'(fault_out_low), 32'h1);
      recover();
    end
    apb(1'b1, MLF_OFS_LIMIT, 32'h7);
    foreach (ri_list[k]) begin
      setup(4'(ri_list[k]), MLF_RESP_RETRY_LO, 3'h0);
      stall <= 1'b1;
      wait_fault(1'b0, n);
      check(32'(gate_cmd), 32'(MLF_GATE_HIZ));
      wait_fault(1'b1, n);
      check(32'(n >= ivl(ri_list[k]) && n <= ivl(ri_list[k]) + 3), 32'h1);
      recover();
    end
    apb(1'b1, MLF_OFS_LIMIT, 32'h0);
    for (int c = 4; c < 8; c++) begin
      setup(4'h0, 4'(c), 3'h0);
      stall <= 1'b1;
      wait_fault(1'b0, n);
      wait_fault(1'b1, n);
      tick(8);
      check(32'(gate_cmd), 32'(latch_gate(4'(c))));
      check(32'(fault_out_low), 32'h0);
      recover();
    end
    // one retry, then lock-free running must restore the full allowance
    setup(4'h0, MLF_RESP_RETRY_HS, 3'h0);
    stall <= 1'b1;
    wait_fault(1'b0, n);
    stall <= 1'b0;
    wait_fault(1'b1, n);
    tick(20);
    stall <= 1'b1;
    tick(5);
    check(32'(gate_cmd), 32'(MLF_GATE_HIZ));
    recover();
    setup(4'h0, 4'h9, 3'h0);
    apb(1'b1, MLF_OFS_MASK, 32'h08);
    probe_timeout <= 1'b1;
    probe_rate_err <= 1'b1;
    cur_loop_sat <= 1'b1;
    spd_loop_sat <= 1'b1;
    apb(1'b0, MLF_OFS_STATUS, 32'h0);
    check(rd & 32'h38, 32'h0);
    check(32'({irq, cur_sat_flag, spd_sat_flag}), 32'h0);
    setup(4'h0, 4'h9, 3'h7);
    tick(3);
    check(32'({irq, cur_sat_flag, spd_sat_flag}), 32'h7);
    apb(1'b0, MLF_OFS_STATUS, 32'h0);
    check(rd & 32'h38, 32'h38);
    probe_timeout <= 1'b0;
    apb(1'b1, MLF_OFS_STATUS, 32'h08);
    tick(2);
    check(32'(irq), 32'h0);
    apb(1'b0, MLF_OFS_STATUS, 32'h0);
    check(rd & 32'h18, 32'h10);
    give_verdict();
  end
endmodule : test_motor_lock_fault_response
